// [hdl/bmi_init_csr.sv]
`timescale 1ns/100ps
module bmi_init_csr
	import bmi_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock, reset, enable
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Load sources, asynchronous, active high
	input  wire logic              global_reset_pin,
	input  wire logic              power_reset_pin,
	input  wire logic              serial_bus_reset,
	// Bus management CSR values
	output logic [31:0]            bandwidth_avail_csr,
	output logic [31:0]            channels_avail_hi_csr,
	output logic [31:0]            channels_avail_lo_csr,
	output logic                   csr_load_pulse
);

	// Complete block state, registered as one word
	typedef struct packed {
		logic                   awready;
		logic                   wready;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   aw_full;
		logic [ADDR_W-1:0]      aw_addr;
		logic                   w_full;
		logic [31:0]            w_data;
		logic [3:0]             w_strb;
		logic                   arready;
		logic                   rvalid;
		logic [1:0]             rresp;
		logic [31:0]            rdata;
		logic [BMI_BW_W-1:0]    bandwidth_seed_field;
		logic [31:0]            channel_map_seed_upper;
		logic [31:0]            channel_map_seed_lower;
		logic [BMI_BW_W-1:0]    bw_csr;
		logic [31:0]            hi_csr;
		logic [31:0]            lo_csr;
		logic                   load_pulse;
		logic [BMI_NUM_SRC-1:0] cause;
		logic [BMI_CNT_W-1:0]   load_cnt;
	} bmi_state_t;

	// Values after system reset; CSRs start equal to the seed defaults
	localparam bmi_state_t BMI_ST_RST = '{
		awready:                1'b1,
		wready:                 1'b1,
		arready:                1'b1,
		bandwidth_seed_field:   BMI_BW_RST,
		channel_map_seed_upper: BMI_CH_RST,
		channel_map_seed_lower: BMI_CH_RST,
		bw_csr:                 BMI_BW_RST,
		hi_csr:                 BMI_CH_RST,
		lo_csr:                 BMI_CH_RST,
		default:                '0
	};

	bmi_state_t             s_r;
	bmi_state_t             s_nxt;
	logic [BMI_NUM_SRC-1:0] load_src;
	logic [BMI_NUM_SRC-1:0] load_ev;

	// Map a byte address onto a register select
	function automatic bmi_sel_t bmi_decode(input logic [ADDR_W-1:0] a);
		bmi_sel_t sel;
		sel = BMI_SEL_NONE;
		if (a == ADDR_W'(BMI_OFF_BW)) begin
			sel = BMI_SEL_BW;
		end else if (a == ADDR_W'(BMI_OFF_CH_HI)) begin
			sel = BMI_SEL_CH_HI;
		end else if (a == ADDR_W'(BMI_OFF_CH_LO)) begin
			sel = BMI_SEL_CH_LO;
		end else if (a == ADDR_W'(BMI_OFF_CTRL)) begin
			sel = BMI_SEL_CTRL;
		end else if (a == ADDR_W'(BMI_OFF_STAT)) begin
			sel = BMI_SEL_STAT;
		end
		return sel;
	endfunction

	// Merge write data into an old word under the byte strobes
	function automatic logic [31:0] bmi_merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < BMI_STRB_W; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Pins cross into aclk through three stages each
	assign load_src[BMI_SRC_GLOBAL] = global_reset_pin;
	assign load_src[BMI_SRC_POWER]  = power_reset_pin;
	assign load_src[BMI_SRC_BUS]    = serial_bus_reset;

	bmi_sync_edge #(
		.W (BMI_NUM_SRC)
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.async_in (load_src),
		.rise     (load_ev)
	);

	// Next-state logic for bus slave, seeds and CSR copies
	always_comb begin
		bmi_sel_t    wsel;
		bmi_sel_t    rsel;
		logic        do_wr;
		logic        srst;
		logic [31:0] merged;
		wsel   = bmi_decode(s_r.aw_addr);
		rsel   = bmi_decode(s_axi_araddr);
		do_wr  = s_r.aw_full && s_r.w_full && !s_r.bvalid;
		srst   = 1'b0;
		merged = '0;
		s_nxt  = s_r;
		s_nxt.load_pulse = 1'b0;

		// Response leaves once the master takes it
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end

		// Address and data are held apart, taken in either order
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.aw_full = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.w_full = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end

		// Commit once both halves are present
		if (do_wr) begin
			s_nxt.aw_full = 1'b0;
			s_nxt.w_full  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = BMI_RESP_OKAY;
			case (wsel)
				BMI_SEL_BW: begin
					merged = bmi_merge(32'(s_r.bandwidth_seed_field),
						s_r.w_data, s_r.w_strb);
					s_nxt.bandwidth_seed_field = merged[BMI_BW_W-1:0];
				end
				BMI_SEL_CH_HI: begin
					s_nxt.channel_map_seed_upper = bmi_merge(
						s_r.channel_map_seed_upper, s_r.w_data, s_r.w_strb);
				end
				BMI_SEL_CH_LO: begin
					s_nxt.channel_map_seed_lower = bmi_merge(
						s_r.channel_map_seed_lower, s_r.w_data, s_r.w_strb);
				end
				BMI_SEL_CTRL: begin
					srst = s_r.w_strb[0] && s_r.w_data[BMI_CTRL_SRST];
				end
				BMI_SEL_STAT: begin
					// Read-only, write dropped quietly
					s_nxt.bresp = BMI_RESP_OKAY;
				end
				default: begin
					s_nxt.bresp = BMI_RESP_SLVERR;
				end
			endcase
		end

		if (srst) begin
			s_nxt.bandwidth_seed_field = BMI_BW_RST;
		end
		if (srst) begin
			s_nxt.channel_map_seed_upper = BMI_CH_RST;
		end
		if (srst) begin
			s_nxt.channel_map_seed_lower = BMI_CH_RST;
		end

		// Copies use the seeds as they stood, so a write in the
		// same cycle lands only at the following load
		if (|load_ev) begin
			s_nxt.bw_csr = s_r.bandwidth_seed_field;
			s_nxt.hi_csr = s_r.channel_map_seed_upper;
			s_nxt.lo_csr = s_r.channel_map_seed_lower;
			s_nxt.load_pulse = 1'b1;
			s_nxt.cause      = load_ev;
			s_nxt.load_cnt   = s_r.load_cnt + 1'b1;
		end

		// Read channel: drop old beat, then take a new address
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = BMI_RESP_OKAY;
			case (rsel)
				BMI_SEL_BW: begin
					s_nxt.rdata = 32'(s_r.bandwidth_seed_field);
				end
				BMI_SEL_CH_HI: begin
					s_nxt.rdata = s_r.channel_map_seed_upper;
				end
				BMI_SEL_CH_LO: begin
					s_nxt.rdata = s_r.channel_map_seed_lower;
				end
				BMI_SEL_CTRL: begin
					s_nxt.rdata = '0;
				end
				BMI_SEL_STAT: begin
					s_nxt.rdata =
						(32'(s_r.load_cnt) << BMI_STAT_CNT_LSB) |
						(32'(s_r.cause) << BMI_STAT_CAUSE_LSB);
				end
				default: begin
					s_nxt.rdata = '0;
					s_nxt.rresp = BMI_RESP_SLVERR;
				end
			endcase
		end

		// Ready flags registered so outputs come from flops
		s_nxt.awready = !s_nxt.aw_full && !s_nxt.bvalid;
		s_nxt.wready  = !s_nxt.w_full && !s_nxt.bvalid;
		s_nxt.arready = !s_nxt.rvalid;
	end

	// system reset and bus reset retention
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= BMI_ST_RST;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign s_axi_awready         = s_r.awready;
	assign s_axi_wready          = s_r.wready;
	assign s_axi_bvalid          = s_r.bvalid;
	assign s_axi_bresp           = s_r.bresp;
	assign s_axi_arready         = s_r.arready;
	assign s_axi_rvalid          = s_r.rvalid;
	assign s_axi_rdata           = s_r.rdata;
	assign s_axi_rresp           = s_r.rresp;
	// CSRs change only on a load or a system reset
	assign bandwidth_avail_csr   = 32'(s_r.bw_csr);
	assign channels_avail_hi_csr = s_r.hi_csr;
	assign channels_avail_lo_csr = s_r.lo_csr;
	assign csr_load_pulse        = s_r.load_pulse;

endmodule

// [hdl/bmi_sync_edge.sv]
`timescale 1ns/100ps
// Three-stage synchroniser with agreement filter and rising-edge pulse
module bmi_sync_edge #(
	parameter int W = 3
) (
	// Clock, reset, enable
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	// Asynchronous levels in, one-cycle pulses out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] rise
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] stab;
		logic [W-1:0] rise;
	} bmi_sync_state_t;

	bmi_sync_state_t s_r;
	bmi_sync_state_t s_nxt;

	// Level is accepted only when stages two and three agree
	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = async_in;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		for (int i = 0; i < W; i++) begin
			if (s_r.s2[i] == s_r.s3[i]) begin
				s_nxt.stab[i] = s_r.s2[i];
			end
		end
		s_nxt.rise = s_nxt.stab & ~s_r.stab;
	end

	// State register, frozen while ce is low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign rise = s_r.rise;

endmodule

// [shared/bmi_pkg.sv]
// Shared constants for the bus management initial-value register bank
package bmi_pkg;

	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] BMI_OFF_BW     = 8'hb0;
	localparam logic [7:0] BMI_OFF_CH_HI  = 8'hb4;
	localparam logic [7:0] BMI_OFF_CH_LO  = 8'hb8;
	localparam logic [7:0] BMI_OFF_CTRL   = 8'hc0;
	localparam logic [7:0] BMI_OFF_STAT   = 8'hc4;

	// Field widths and reset values
	localparam int          BMI_DATA_W    = 32;
	localparam int          BMI_STRB_W    = 4;
	localparam int          BMI_BW_W      = 13;
	localparam logic [12:0] BMI_BW_RST    = 13'h1333;
	localparam logic [31:0] BMI_CH_RST    = 32'hffffffff;

	// Control register: write one to bit 0 for a software reset
	localparam int          BMI_CTRL_SRST = 0;

	// Status register layout
	localparam int          BMI_STAT_CAUSE_LSB = 0;
	localparam int          BMI_STAT_CNT_LSB   = 8;
	localparam int          BMI_CNT_W          = 8;

	// Load source indices in the synchroniser vector
	localparam int          BMI_SRC_GLOBAL = 0;
	localparam int          BMI_SRC_POWER  = 1;
	localparam int          BMI_SRC_BUS    = 2;
	localparam int          BMI_NUM_SRC    = 3;

	// AXI response codes
	localparam logic [1:0]  BMI_RESP_OKAY   = 2'b00;
	localparam logic [1:0]  BMI_RESP_SLVERR = 2'b10;

	// Register select produced by address decode
	typedef enum logic [2:0] {
		BMI_SEL_NONE,
		BMI_SEL_BW,
		BMI_SEL_CH_HI,
		BMI_SEL_CH_LO,
		BMI_SEL_CTRL,
		BMI_SEL_STAT
	} bmi_sel_t;

endpackage

// [tb/bmi_host.sv]
`timescale 1ns/100ps
// Register-bus master standing in for host software
module bmi_host (
	// Clock
	input wire logic  aclk,
	// Write side
	output logic [7:0]  s_axi_awaddr,
	output logic [2:0]  s_axi_awprot,
	output logic        s_axi_awvalid,
	input wire logic    s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0]  s_axi_wstrb,
	output logic        s_axi_wvalid,
	input wire logic    s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic    s_axi_bvalid,
	output logic        s_axi_bready,
	// Read side
	output logic [7:0]  s_axi_araddr,
	output logic [2:0]  s_axi_arprot,
	output logic        s_axi_arvalid,
	input wire logic    s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic    s_axi_rvalid,
	output logic        s_axi_rready
);
	// Idle bus at time zero
	initial begin
		{s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
	end

	// Released lines show inverted data so stale values never match
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad, wd;
		int   lag;
		ad = 0;
		wd = 0;
		// Late bready now and then, so the slave must hold its answer
		lag = $urandom() % 3;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (lag == 0);
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
				ad = 1;
			end
			if (!wd && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
				wd = 1;
			end
		end
		repeat (lag) @(posedge aclk);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int lag;
		// Late rready now and then, so read data must stand
		lag = $urandom() % 3;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (lag == 0);
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		repeat (lag) @(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// [tb/bmi_init_csr_monitor.sv]
`timescale 1ns/100ps
// Port-level checks on the initial-value register bank
module bmi_init_csr_monitor (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Load sources and CSR values
	input wire logic        global_reset_pin,
	input wire logic        power_reset_pin,
	input wire logic        serial_bus_reset,
	input wire logic [31:0] bandwidth_avail_csr,
	input wire logic [31:0] channels_avail_hi_csr,
	input wire logic [31:0] channels_avail_lo_csr,
	input wire logic        csr_load_pulse
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_bw_upper: assert property (bandwidth_avail_csr[31:13] == 19'h0)
		else $error("bandwidth csr upper bits set");
	chk_csr_hold: assert property (!csr_load_pulse && $past(aresetn)
		|-> $stable({bandwidth_avail_csr, channels_avail_hi_csr,
		channels_avail_lo_csr})) else $error("csr moved without load");
	// Any source edge leads to a load a few cycles on
	chk_load_follow: assert property ($rose(global_reset_pin |
		power_reset_pin | serial_bus_reset) |-> ##[3:5] csr_load_pulse)
		else $error("no load after source edge");
	chk_pulse_once: assert property (csr_load_pulse |=> !csr_load_pulse)
		else $error("load pulse too long");
	chk_b_after: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	chk_b_stand: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
	chk_r_after: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	chk_r_stand: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
endmodule

bind bmi_init_csr bmi_init_csr_monitor u_mon (.*);

// [tb/bus_mgmt_csr_initial_values_test.sv]
`timescale 1ns/100ps
// Self-checking bench for the initial-value register bank
module bus_mgmt_csr_initial_values_test;
	import bmi_pkg::*;
	logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, csr_load_pulse;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot, ld;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_wdata, s_axi_rdata, bandwidth_avail_csr, d, v;
	logic [31:0] channels_avail_hi_csr, channels_avail_lo_csr;
	logic [31:0] seed_m [3], csr_m [3];
	logic [7:0]  offs [3] = '{BMI_OFF_BW, BMI_OFF_CH_HI, BMI_OFF_CH_LO};
	int          err_total, n_tests, cnt, cyc;
	wire global_reset_pin = ld[0];
	wire power_reset_pin  = ld[1];
	wire serial_bus_reset = ld[2];

	bmi_init_csr dut (.*);
	bmi_host u_host (.*);

	// 40 MHz clock
	initial begin
		aclk = 0;
		forever #12.5 aclk = ~aclk;
	end

	// Hang guard, well above the expected run length
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			complete_run;
		end
	end

	task chk(string nm, logic [31:0] s, logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk_seeds;
		for (int i = 0; i < 3; i++) begin
			u_host.rd(offs[i], d, r);
			chk("seed", d, seed_m[i]);
			chk("rresp", r, BMI_RESP_OKAY);
		end
	endtask

	task chk_csr;
		chk("bw csr", bandwidth_avail_csr, csr_m[0]);
		chk("hi csr", channels_avail_hi_csr, csr_m[1]);
		chk("lo csr", channels_avail_lo_csr, csr_m[2]);
	endtask

	// One source edge copies all seeds into the CSRs
	task load(int i);
		int k;
		k = 0;
		@(posedge aclk);
		ld[i] <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
		end while (!csr_load_pulse && k < 20);
		ld[i] <= 1'b0;
		chk("pulse", csr_load_pulse, 1);
		csr_m = seed_m;
		cnt++;
		repeat (6) @(posedge aclk);
		chk_csr;
		u_host.rd(BMI_OFF_STAT, d, r);
		chk("stat", d, {16'h0, cnt[7:0], 5'h0, 3'b001 << i});
	endtask

	initial begin
		{ld, aresetn, err_total, n_tests, cnt} = '0;
		ce = 1'b1;
		d = $urandom(44);
		seed_m = '{32'h1333, 32'hffffffff, 32'hffffffff};
		csr_m = seed_m;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		chk_seeds;
		chk_csr;
		u_host.rd(8'hbc, d, r);
		chk("rresp", r, BMI_RESP_SLVERR);
		chk("rdata", d, 0);
		u_host.wr(8'hbc, 32'h0, r);
		chk("bresp", r, BMI_RESP_SLVERR);
		for (int j = 0; j < 3; j++) begin
			// random writes, CSRs untouched until a load
			for (int i = 0; i < 3; i++) begin
				v = $urandom();
				u_host.wr(offs[i], v, r);
				seed_m[i] = (i == 0) ? (v & 32'h1fff) : v;
				chk("bresp", r, BMI_RESP_OKAY);
			end
			chk_seeds;
			chk_csr;
			load(j);
		end
		chk_seeds;
		// software reset restores seeds, not the CSRs
		u_host.wr(BMI_OFF_CTRL, 32'h1, r);
		seed_m = '{32'h1333, 32'hffffffff, 32'hffffffff};
		chk_seeds;
		chk_csr;
		load(1);
		// Clear all seeds and load them, so a system reset shows
		for (int i = 0; i < 3; i++) begin
			u_host.wr(offs[i], 32'h0, r);
			chk("bresp", r, BMI_RESP_OKAY);
			seed_m[i] = 32'h0;
		end
		load(2);
		// Mid-run system reset puts seeds, CSRs and status back
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		seed_m = '{32'h1333, 32'hffffffff, 32'hffffffff};
		csr_m = seed_m;
		cnt = 0;
		chk_seeds;
		chk_csr;
		u_host.rd(BMI_OFF_STAT, d, r);
		chk("stat", d, 32'h0);
		complete_run;
	end
endmodule
